// *** core/itr_cfg.svh ***
`ifndef ITR_CFG_SVH
`define ITR_CFG_SVH
// register byte offsets on the bus
`define ITR_OFF_CTRL      12'h000
`define ITR_OFF_STAT      12'h004
`define ITR_OFF_FLAGS     12'h008
`define ITR_ARR_REGION    5'h01
// wide register count and indices, entry at 0x080 + 8*index
`define ITR_NUM_WIDE      11
`define ITR_IDX_CODE_D    4'h0
`define ITR_IDX_STACK_D   4'h1
`define ITR_IDX_CTL_FLG   4'h2
`define ITR_IDX_IOB       4'h3
`define ITR_IDX_TSD       4'h4
`define ITR_IDX_PF_DIR    4'h5
`define ITR_IDX_DEF_CTL   4'h6
`define ITR_IDX_PT_BASE   4'h7
`define ITR_IDX_SP        4'h8
`define ITR_IDX_IP        4'h9
`define ITR_IDX_INTR      4'ha
// control word fields
`define ITR_CTRL_DI       0
`define ITR_CTRL_CPL      1
`define ITR_CTRL_MASK     32'h0000_0007
// legacy flags fields and reset
`define ITR_FLG_TF        8
`define ITR_FLG_IF        9
`define ITR_FLG_IOPL      12
`define ITR_FLG_AC        18
`define ITR_RST_FLAGS     32'h0000_0002
// transfer vectors and codes
`define ITR_VEC_INST      8'h00
`define ITR_VEC_GATE      8'h01
`define ITR_VEC_SYSF      8'h02
`define ITR_VEC_DIS       8'h10
`define ITR_VEC_EXT       8'h20
`define ITR_VEC_SWI       8'h21
`define ITR_VEC_FAULT     8'h22
`define ITR_VEC_TRAP      8'h23
`define ITR_VEC_MCHK      8'h24
`define ITR_CODE_CALL     2'h0
`define ITR_CODE_JMP      2'h1
`define ITR_CODE_TASK     2'h2
`define ITR_CODE_FLAGS    2'h2
`define ITR_CODE_SS       2'h3
// bus responses and control register numbers
`define ITR_RESP_OKAY     2'h0
`define ITR_RESP_SLVERR   2'h2
`define ITR_CR0           3'h0
`define ITR_CR2           3'h2
`define ITR_CR3           3'h3
`define ITR_CR4           3'h4
`endif

// *** core/itr_pkg.sv ***
`default_nettype none
`include "itr_cfg.svh"
package itr_pkg;
  // which instruction set is executing
  typedef enum logic {ITR_NATIVE = 1'b0, ITR_LEGACY = 1'b1} itr_mode_type;
  // class of the retiring instruction
  typedef enum logic [2:0] {
    ITR_K_PLAIN = 3'b000, ITR_K_TO_LEGACY = 3'b001, ITR_K_PRIV = 3'b010, ITR_K_FLAGS = 3'b011,
    ITR_K_SS_LOAD = 3'b100, ITR_K_GATE_CALL = 3'b101, ITR_K_GATE_JMP = 3'b110, ITR_K_TASK = 3'b111
  } itr_kind_type;
  // whole state of the top module
  typedef struct packed {
    itr_mode_type                       mode;
    logic [31:0]                        ctrl;
    logic [31:0]                        flags;
    logic [`ITR_NUM_WIDE-1:0][63:0]     wide;
    logic                               aw_held;
    logic [11:0]                        aw_addr;
    logic                               w_held;
    logic [31:0]                        wdata;
    logic [3:0]                         wstrb;
    logic                               awready;
    logic                               wready;
    logic                               bvalid;
    logic [1:0]                         bresp;
    logic                               arready;
    logic                               rvalid;
    logic [31:0]                        rdata;
    logic [1:0]                         rresp;
    logic                               xfer;
    logic [7:0]                         vec;
    logic [1:0]                         code;
    logic                               nullify;
    logic                               cr_valid;
    logic [63:0]                        cr_data;
  } itr_state_type;
endpackage
`default_nettype wire

// *** core/itr_core_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// joins the top to its decision and flag filter units
interface itr_core_if;
  import itr_pkg::*;
  logic         instr_valid;   // an instruction retires at a boundary
  itr_kind_type kind;          // its class
  logic         di;            // transition disable
  itr_mode_type mode;          // current set
  logic         mchk, fault, trap, swint, ext_irq;
  logic         sys_change;    // filtered flags change a system bit
  logic         take;          // go to native handler
  logic [7:0]   vector;
  logic [1:0]   code;
  logic         nullify;
  logic         enter;         // switch to legacy set
  logic [31:0]  old_flags, new_flags, filtered;
  logic [1:0]   cpl;
  modport dec (input instr_valid, kind, di, mode, mchk, fault, trap, swint, ext_irq, sys_change,
               output take, vector, code, nullify, enter);
  modport flt (input old_flags, new_flags, cpl, output filtered, sys_change);
endinterface
`default_nettype wire

// *** core/itr_flag_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "itr_cfg.svh"
module itr_flag_filter import itr_pkg::*; (
  itr_core_if.flt f
);
  logic perm_if;  // privilege may change interrupt enable
  logic perm_io;  // privilege may change io field
  // gate each protected flag by privilege, then spot system bit changes
  always_comb begin
    perm_if = (f.cpl <= f.old_flags[`ITR_FLG_IOPL +: 2]);
    perm_io = (f.cpl == 2'h0);
    f.filtered = f.new_flags;
    if (!perm_if) begin
      f.filtered[`ITR_FLG_IF] = f.old_flags[`ITR_FLG_IF];
    end
    if (!perm_io) begin
      f.filtered[`ITR_FLG_IOPL +: 2] = f.old_flags[`ITR_FLG_IOPL +: 2];
    end
    f.filtered[1] = 1'b1;
    // no permission means no change and no interception
    f.sys_change = (f.filtered[`ITR_FLG_IF] != f.old_flags[`ITR_FLG_IF]) ||
                   (f.filtered[`ITR_FLG_TF] != f.old_flags[`ITR_FLG_TF]) ||
                   (f.filtered[`ITR_FLG_AC] != f.old_flags[`ITR_FLG_AC]);
  end
endmodule // itr_flag_filter
`default_nettype wire

// *** core/itr_decide.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "itr_cfg.svh"
module itr_decide import itr_pkg::*; (
  itr_core_if.dec c
);
  logic leg_ret;  // legacy instruction retiring
  // prioritised choice of the next transfer
  always_comb begin
    leg_ret = c.instr_valid && (c.mode == ITR_LEGACY);
    c.take = 1'b0;
    c.vector = `ITR_VEC_INST;
    c.code = 2'h0;
    c.nullify = 1'b0;
    c.enter = 1'b0;
    if (c.mchk) begin
      c.take = 1'b1;
      c.vector = `ITR_VEC_MCHK;
    end else if (c.fault) begin
      c.take = 1'b1;
      c.vector = `ITR_VEC_FAULT;
    end else if (c.instr_valid && c.kind == ITR_K_TO_LEGACY && c.mode == ITR_NATIVE && c.di) begin
      c.take = 1'b1;
      c.nullify = 1'b1;
      c.vector = `ITR_VEC_DIS;
    end else if (c.trap || c.swint) begin
      c.take = 1'b1;
      c.vector = c.trap ? `ITR_VEC_TRAP : `ITR_VEC_SWI;
    end else if (leg_ret && c.kind == ITR_K_PRIV) begin
      c.take = 1'b1;
      c.vector = `ITR_VEC_INST;
    end else if (leg_ret && (c.kind == ITR_K_GATE_CALL || c.kind == ITR_K_GATE_JMP || c.kind == ITR_K_TASK)) begin
      c.take = 1'b1;
      c.vector = `ITR_VEC_GATE;
      c.code = (c.kind == ITR_K_GATE_CALL) ? `ITR_CODE_CALL :
               (c.kind == ITR_K_GATE_JMP) ? `ITR_CODE_JMP : `ITR_CODE_TASK;
    end else if (leg_ret && ((c.kind == ITR_K_FLAGS && c.sys_change) || c.kind == ITR_K_SS_LOAD)) begin
      c.take = 1'b1;
      c.vector = `ITR_VEC_SYSF;
      c.code = (c.kind == ITR_K_SS_LOAD) ? `ITR_CODE_SS : `ITR_CODE_FLAGS;
    end else if (c.ext_irq) begin
      c.take = 1'b1;
      c.vector = `ITR_VEC_EXT;
    end else if (c.instr_valid && c.kind == ITR_K_TO_LEGACY && c.mode == ITR_NATIVE) begin
      c.enter = 1'b1;
    end
  end
endmodule // itr_decide
`default_nettype wire

// *** core/itr_transition_top.sv ***
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "itr_cfg.svh"
module itr_transition_top import itr_pkg::*; (
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output var  logic        s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output var  logic        s_axi_wready_o,
  output var  logic [1:0]  s_axi_bresp_o,
  output var  logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output var  logic        s_axi_arready_o,
  output var  logic [31:0] s_axi_rdata_o,
  output var  logic [1:0]  s_axi_rresp_o,
  output var  logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // retiring instruction from the core
  input  wire logic        instr_valid_i,
  input  wire logic [2:0]  instr_kind_i,
  input  wire logic [31:0] flags_new_i,
  // events from the core and interrupt logic
  input  wire logic        mchk_i,
  input  wire logic        fault_i,
  input  wire logic        trap_i,
  input  wire logic        swint_i,
  input  wire logic        ext_irq_i,
  // legacy execution results
  input  wire logic        res_valid_i,
  input  wire logic [3:0]  res_sel_i,
  input  wire logic [63:0] res_data_i,
  // legacy control register reads
  input  wire logic        cr_rd_i,
  input  wire logic [2:0]  cr_num_i,
  output var  logic        cr_rd_valid_o,
  output var  logic [63:0] cr_rd_data_o,
  // transfer report
  output var  logic        legacy_mode_o,
  output var  logic        xfer_o,
  output var  logic [7:0]  xfer_vector_o,
  output var  logic [1:0]  xfer_code_o,
  output var  logic        nullify_o,
  // shared and legacy state to the core
  output var  logic [31:0] legacy_flags_o,
  output var  logic [63:0] default_control_register_o,
  output var  logic [63:0] page_table_base_o,
  output var  logic [63:0] io_port_base_o,
  output var  logic [63:0] task_state_desc_o
);
  itr_state_type q;          // registered state
  itr_state_type d;          // next state
  logic [32:0]   rd_w;       // read error and data
  logic          wr_fire;    // a bus write commits this cycle while no earlier response is held
  logic [63:0]   pf_dir_w;   // kernel register 2 view
  logic [63:0]   ctl_flags_w; // control flags view
  logic [1:0]    cpl_w;      // current privilege level
  logic          flg_commit; // legacy flags write completes

  itr_core_if u_if ();       // carrier to the units

  // unit inputs
  assign u_if.instr_valid = instr_valid_i;
  assign u_if.kind        = itr_kind_type'(instr_kind_i);
  assign u_if.di          = q.ctrl[`ITR_CTRL_DI];
  assign u_if.mode        = q.mode;
  assign u_if.mchk        = mchk_i;
  assign u_if.fault       = fault_i;
  assign u_if.trap        = trap_i;
  assign u_if.swint       = swint_i;
  assign u_if.ext_irq     = ext_irq_i;
  assign u_if.old_flags   = q.flags;
  assign u_if.new_flags   = flags_new_i;
  assign u_if.cpl         = cpl_w;
  assign cpl_w            = q.ctrl[`ITR_CTRL_CPL +: 2];
  assign pf_dir_w         = q.wide[`ITR_IDX_PF_DIR];
  assign ctl_flags_w      = q.wide[`ITR_IDX_CTL_FLG];

  // privilege filter on legacy flag writes
  itr_flag_filter u_flt (
    .f (u_if.flt)
  );

  // transfer decision
  itr_decide u_dec (
    .c (u_if.dec)
  );

  // byte-lane merge of a bus write
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // read decode, bit 32 flags an unmapped address
  function automatic logic [32:0] rd_word(input itr_state_type s, input logic [11:0] a);
    logic [3:0]  idx;
    logic [11:0] wa;
    logic [32:0] r;
    idx = a[6:3];
    wa  = {a[11:2], 2'b00};
    r   = {1'b1, 32'h0000_0000};
    if (wa == `ITR_OFF_CTRL) begin
      r = {1'b0, s.ctrl};
    end else if (wa == `ITR_OFF_STAT) begin
      // mode and last vector, read only
      r = {1'b0, 23'h00_0000, s.wide[`ITR_IDX_INTR][7:0], s.mode};
    end else if (wa == `ITR_OFF_FLAGS) begin
      r = {1'b0, s.flags};
    end else if (a[11:7] == `ITR_ARR_REGION && idx < 4'(`ITR_NUM_WIDE)) begin
      r = {1'b0, a[2] ? s.wide[idx][63:32] : s.wide[idx][31:0]};
    end
    return r;
  endfunction

  assign rd_w       = rd_word(q, s_axi_araddr_i);
  assign wr_fire    = d.bvalid && !q.bvalid;
  assign flg_commit = instr_valid_i && instr_kind_i == ITR_K_FLAGS && q.mode == ITR_LEGACY &&
                      !mchk_i && !fault_i;

  // next state: bus slave, then hardware updates which win over software
  always_comb begin
    logic [3:0] widx;
    widx = 4'h0;
    d = q;
    d.xfer = 1'b0;
    d.nullify = 1'b0;
    d.cr_valid = 1'b0;
    // write address and data, either order
    if (s_axi_awvalid_i && q.awready) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && q.wready) begin
      d.w_held = 1'b1;
      d.wdata = s_axi_wdata_i;
      d.wstrb = s_axi_wstrb_i;
    end
    if (q.bvalid && s_axi_bready_i) begin
      d.bvalid = 1'b0;
    end
    widx = d.aw_addr[6:3];
    // commit once both halves are in and no response is pending
    if (d.aw_held && d.w_held && !d.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `ITR_RESP_OKAY;
      if ({d.aw_addr[11:2], 2'b00} == `ITR_OFF_CTRL) begin
        // disable bit and privilege level
        d.ctrl = merge(q.ctrl, d.wdata, d.wstrb) & `ITR_CTRL_MASK;
      end else if ({d.aw_addr[11:2], 2'b00} == `ITR_OFF_FLAGS) begin
        d.flags = merge(q.flags, d.wdata, d.wstrb);
      end else if (d.aw_addr[11:7] == `ITR_ARR_REGION && widx < 4'(`ITR_NUM_WIDE)) begin
        if (widx == `ITR_IDX_CTL_FLG && cpl_w != 2'h0) begin
          d.bresp = `ITR_RESP_SLVERR;
        end else if (d.aw_addr[2]) begin
          d.wide[widx][63:32] = merge(q.wide[widx][63:32], d.wdata, d.wstrb);
        end else begin
          d.wide[widx][31:0] = merge(q.wide[widx][31:0], d.wdata, d.wstrb);
        end
      end else if ({d.aw_addr[11:2], 2'b00} != `ITR_OFF_STAT) begin
        d.bresp = `ITR_RESP_SLVERR;
      end
    end
    d.awready = !d.aw_held;
    d.wready = !d.w_held;
    // read channel
    if (q.rvalid && s_axi_rready_i) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd_w[31:0];
      d.rresp = rd_w[32] ? `ITR_RESP_SLVERR : `ITR_RESP_OKAY;
    end
    d.arready = !d.rvalid;
    // legacy results land in legacy state or shared pointers only
    if (res_valid_i) begin
      if (res_sel_i == `ITR_IDX_SP || res_sel_i == `ITR_IDX_IP) begin
        d.wide[res_sel_i] = res_data_i;
      end else if (q.mode == ITR_LEGACY && (res_sel_i == `ITR_IDX_CODE_D || res_sel_i == `ITR_IDX_STACK_D)) begin
        d.wide[res_sel_i] = res_data_i;
      end
      // any other selection is dropped, preserved state stays put
    end
    // filtered legacy flags write
    if (flg_commit) begin
      d.flags = u_if.filtered;
    end
    // legacy control register reads
    if (cr_rd_i) begin
      d.cr_valid = 1'b1;
      unique case (cr_num_i)
        `ITR_CR0, `ITR_CR4: d.cr_data = ctl_flags_w;
        `ITR_CR2, `ITR_CR3: d.cr_data = pf_dir_w;
        default: d.cr_data = 64'h0;
      endcase
    end
    // set switch
    if (u_if.take) begin
      d.mode = ITR_NATIVE;
      d.xfer = 1'b1;
      d.vec = u_if.vector;
      d.code = u_if.code;
      d.nullify = u_if.nullify;
      d.wide[`ITR_IDX_INTR] = {q.wide[`ITR_IDX_IP][31:0], u_if.code, 14'h0000, 8'h00, u_if.vector};
    end else if (u_if.enter) begin
      d.mode = ITR_LEGACY;
    end
  end

  // state register
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
      q.flags <= `ITR_RST_FLAGS;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state
  assign s_axi_awready_o   = q.awready;
  assign s_axi_wready_o    = q.wready;
  assign s_axi_bvalid_o    = q.bvalid;
  assign s_axi_bresp_o     = q.bresp;
  assign s_axi_arready_o   = q.arready;
  assign s_axi_rvalid_o    = q.rvalid;
  assign s_axi_rdata_o     = q.rdata;
  assign s_axi_rresp_o     = q.rresp;
  assign cr_rd_valid_o     = q.cr_valid;
  assign cr_rd_data_o      = q.cr_data;
  assign legacy_mode_o     = q.mode;
  assign xfer_o            = q.xfer;
  assign xfer_vector_o     = q.vec;
  assign xfer_code_o       = q.code;
  assign nullify_o         = q.nullify;
  assign legacy_flags_o    = q.flags;
  assign default_control_register_o = q.wide[`ITR_IDX_DEF_CTL];
  assign page_table_base_o          = q.wide[`ITR_IDX_PT_BASE];
  assign io_port_base_o    = q.wide[`ITR_IDX_IOB];
  assign task_state_desc_o = q.wide[`ITR_IDX_TSD];

  // blocked entry stays native and nullifies
  a_di_blocks_entry: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (instr_valid_i && instr_kind_i == ITR_K_TO_LEGACY && q.ctrl[`ITR_CTRL_DI] && !legacy_mode_o)
    |=> (!legacy_mode_o && nullify_o))
    else $error("entry taken while disabled");

  // blocked entry reports the disabled fault
  a_dis_fault_vec: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (instr_valid_i && instr_kind_i == ITR_K_TO_LEGACY && q.ctrl[`ITR_CTRL_DI] && !legacy_mode_o &&
     !mchk_i && !fault_i)
    |=> (xfer_o && xfer_vector_o == `ITR_VEC_DIS))
    else $error("disabled fault missing");

  // privileged legacy instruction intercepts at its boundary
  a_priv_intercept: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (legacy_mode_o && instr_valid_i && instr_kind_i == ITR_K_PRIV && !mchk_i && !fault_i && !trap_i &&
     !swint_i)
    |=> (xfer_o && xfer_vector_o == `ITR_VEC_INST && !legacy_mode_o))
    else $error("instruction interception missing");

  // gate call is reported with its code
  a_gate_call_code: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (legacy_mode_o && instr_valid_i && instr_kind_i == ITR_K_GATE_CALL && !mchk_i && !fault_i &&
     !trap_i && !swint_i)
    |=> (xfer_vector_o == `ITR_VEC_GATE && xfer_code_o == `ITR_CODE_CALL) ##1 !xfer_o)
    else $error("gate interception wrong");

  // any event forces native whatever the disable bit
  a_event_to_native: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (mchk_i || fault_i || trap_i || swint_i || ext_irq_i) |=> (xfer_o && !legacy_mode_o))
    else $error("event left legacy set running");

  // external interrupt vector independent of mode
  a_ext_irq_same: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (ext_irq_i && !instr_valid_i && !mchk_i && !fault_i && !trap_i && !swint_i)
    |=> (xfer_vector_o == `ITR_VEC_EXT))
    else $error("external interrupt mishandled");

  // control flags frozen outside level zero
  a_legacy_control_flags_guard: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (cpl_w != 2'h0 && $stable(cpl_w)) |=> $stable(ctl_flags_w))
    else $error("control flags written above level zero");

  // legacy results never reach the default control register
  a_dcr_untouched: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (res_valid_i && res_sel_i == `ITR_IDX_DEF_CTL && !wr_fire) |=> $stable(default_control_register_o))
    else $error("preserved register altered");

  // io field protected from legacy writes above level zero
  a_iopl_guard: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (flg_commit && cpl_w != 2'h0 && !wr_fire)
    |=> (legacy_flags_o[`ITR_FLG_IOPL +: 2] == $past(q.flags[`ITR_FLG_IOPL +: 2])))
    else $error("io field changed without privilege");

  // cr2 and cr3 read kernel register 2
  a_cr2_read_map: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (cr_rd_i && (cr_num_i == `ITR_CR2 || cr_num_i == `ITR_CR3)) |=> (cr_rd_valid_o && cr_rd_data_o == $past(pf_dir_w)))
    else $error("cr2 cr3 read wrong");

  // cr0 and cr4 read the control flags
  a_cr0_read_map: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (cr_rd_i && (cr_num_i == `ITR_CR0 || cr_num_i == `ITR_CR4)) |=> (cr_rd_data_o == $past(ctl_flags_w)))
    else $error("cr0 cr4 read wrong");

  // every transfer records its vector in the interruption state
  a_intr_state_rec: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    xfer_o |-> (q.wide[`ITR_IDX_INTR] ==
                {$past(q.wide[`ITR_IDX_IP][31:0]), xfer_code_o, 14'h0000, 8'h00, xfer_vector_o}))
    else $error("interruption state not recorded");
endmodule // itr_transition_top
`default_nettype wire

// *** test/itr_transition_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module itr_transition_top_tb;
  // bench-driven inputs, all zero at time zero except s_axi_wstrb_i, which starts at all ones
  logic        mclk_i = 0, reset_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0, instr_valid_i = 0, mchk_i = 0, fault_i = 0;
  logic        trap_i = 0, swint_i = 0, ext_irq_i = 0, res_valid_i = 0, cr_rd_i = 0;
  logic [11:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, flags_new_i = '0;
  logic [3:0]  s_axi_wstrb_i = 4'hf, res_sel_i = '0;
  logic [2:0]  instr_kind_i = '0, cr_num_i = '0;
  logic [63:0] res_data_i = '0;
  // design outputs
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic        cr_rd_valid_o, legacy_mode_o, xfer_o, nullify_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, xfer_code_o;
  logic [31:0] s_axi_rdata_o, legacy_flags_o, rd;
  logic [63:0] cr_rd_data_o, default_control_register_o, page_table_base_o, io_port_base_o, task_state_desc_o;
  logic [7:0]  vt [5] = '{8'h24, 8'h22, 8'h23, 8'h21, 8'h20}; // event vectors
  logic [7:0]  xfer_vector_o;
  logic [1:0]  rs;                   // last bus response
  int          num_errors = 0, compares = 0;

  // free-running 25 MHz clock
  always #20 mclk_i = ~mclk_i;

  itr_transition_top dut (.*);

  // one compare for every kind of result
  task automatic chk(input string n, input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // bus write, both halves offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {s_axi_awaddr_i, s_axi_wdata_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= {a, d, 3'b111};
    do begin
      @(posedge mclk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    rs = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask

  // bus read, word and response kept in rd and rs
  task automatic rdw(input logic [11:0] a);
    @(posedge mclk_i);
    {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'b11};
    do begin
      @(posedge mclk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    {rd, rs} = {s_axi_rdata_o, s_axi_rresp_o};
    s_axi_rready_i <= 1'b0;
  endtask

  // one retiring instruction or event; x = {xfer, vector, code}
  task automatic ev(input logic v, input logic [2:0] k, input logic [4:0] e, input logic [10:0] x, input logic m);
    @(posedge mclk_i);
    {instr_valid_i, instr_kind_i, mchk_i, fault_i, trap_i, swint_i, ext_irq_i} <= {v, k, e};
    @(posedge mclk_i);
    {instr_valid_i, mchk_i, fault_i, trap_i, swint_i, ext_irq_i} <= '0;
    #1;
    chk("xfer", xfer_o, x[10]);
    chk("nullify", nullify_o, x[10:2] == 9'h110);
    if (x[10]) chk("vector", xfer_vector_o, x[9:2]);
    if (x[10] && x[9:2] inside {8'h01, 8'h02}) chk("code", xfer_code_o, x[1:0]);
    chk("mode", legacy_mode_o, m);
  endtask

  // legacy control register read, one-cycle answer
  task automatic cr(input logic [2:0] n, input logic [63:0] e);
    @(posedge mclk_i);
    {cr_rd_i, cr_num_i} <= {1'b1, n};
    @(posedge mclk_i);
    cr_rd_i <= 1'b0;
    #1;
    chk("cr_valid", cr_rd_valid_o, 1'b1);
    chk("cr_data", cr_rd_data_o, e);
  endtask

  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rdw(12'h008); chk("flags_rst", rd, 32'h2);
    rdw(12'h040); chk("unmapped", rs, 2'h2);
    wr(12'h000, 32'h1);
    ev(1, 3'd1, 0, {1'b1, 8'h10, 2'h0}, 0);
    wr(12'h000, 32'h0);
    ev(1, 3'd1, 0, 11'h0, 1);
    ev(1, 3'd2, 0, {1'b1, 8'h00, 2'h0}, 0);
    // gate, task and stack-load interceptions
    for (int i = 0; i < 4; i++) begin
      ev(1, 3'd1, 0, 11'h0, 1);
      ev(1, i == 3 ? 3'd4 : 3'(5 + i), 0, {1'b1, i == 3 ? 8'h02 : 8'h01, 2'(i)}, 0);
    end
    // each event leaves legacy even with entry disabled
    for (int i = 0; i < 5; i++) begin
      ev(1, 3'd1, 0, 11'h0, 1);
      wr(12'h000, 32'h1);
      ev(0, 3'd0, 5'h10 >> i, {1'b1, vt[i], 2'h0}, 0);
      wr(12'h000, 32'h0);
    end
    ev(1, 3'd1, 0, 11'h0, 1);
    @(posedge mclk_i) flags_new_i <= 32'h202;
    ev(1, 3'd3, 0, {1'b1, 8'h02, 2'h2}, 0);
    rdw(12'h008); chk("flags", rd, 32'h202);
    chk("flags_out", legacy_flags_o, 32'h202);
    rdw(12'h004); chk("status", rd, 32'h4);
    rdw(12'h0d0); chk("intr_state", rd, 32'h8000_0002);
    wr(12'h090, 32'h8000_0011);
    wr(12'h094, 32'h0000_0600);
    cr(3'd0, 64'h0000_0600_8000_0011);
    wr(12'h000, 32'h4);
    wr(12'h090, 32'h0); chk("ctl_flags_lock", rs, 2'h2);
    cr(3'd4, 64'h0000_0600_8000_0011);
    wr(12'h0a8, 32'h1234_5678);
    wr(12'h0ac, 32'h9abc_def0);
    cr(3'd2, 64'h9abc_def0_1234_5678);
    cr(3'd3, 64'h9abc_def0_1234_5678);
    wr(12'h098, 32'h31);
    wr(12'h0a0, 32'h41);
    wr(12'h0b0, 32'h61);
    wr(12'h0b8, 32'h71);
    chk("outs", {io_port_base_o[7:0], task_state_desc_o[7:0], default_control_register_o[7:0],
                 page_table_base_o[7:0]}, 32'h3141_6171);
    @(posedge mclk_i) {res_valid_i, res_sel_i, res_data_i} <= {1'b1, 4'h6, 64'h5a5a};
    @(posedge mclk_i) res_sel_i <= 4'h8;
    @(posedge mclk_i) res_valid_i <= 1'b0;
    chk("preserved", default_control_register_o, 64'h61);
    rdw(12'h0c0); chk("sp", rd, 32'h5a5a);
    stop_test();
  end

  // watchdog, far beyond the expected run
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end
endmodule // itr_transition_top_tb
`default_nettype wire
